//--- rtl/acpm_priv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "acpm_cfg.svh"
module acpm_priv_ctrl #(
  parameter int NIRQ  = 8,
  parameter int FEATW = 16,
  parameter int NRES  = 32
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // option straps and fuse level
  input  wire logic              i_test_off_strap,
  input  wire logic              i_opt_health,
  input  wire logic              i_opt_pdc,
  // exception and interrupt sources
  input  wire logic              i_exc_req,
  input  wire logic [NIRQ-1:0]   i_evt_irq,
  // resource access check
  input  wire logic              i_acc_req,
  input  wire logic [4:0]        i_acc_res,
  output logic                   o_acc_block,
  // mode and vector
  output acpm_pkg::acpm_mode_e   o_mode,
  output logic                   o_vec_jump,
  output logic      [31:0]       o_vec_addr,
  // side effects
  output logic                   o_wdt_abort,
  output logic                   o_test_off_burn,
  output logic                   o_selftest_start,
  output logic                   o_ident_send,
  output logic      [FEATW-1:0]  o_feat_en,
  output logic                   o_irq
);
  import acpm_pkg::*;

  if (NIRQ < 1 || NIRQ > 16) begin : g_chk_irq
    $error("NIRQ must be 1..16");
  end
  if (FEATW < 1 || FEATW > 32) begin : g_chk_feat
    $error("FEATW must be 1..32");
  end
  if (NRES < 1 || NRES > 32) begin : g_chk_res
    $error("NRES must be 1..32");
  end

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] vec_at(input logic [31:0] base, input logic [4:0] idx);
    vec_at = base + {25'h0, idx, 2'b00};
  endfunction

  function automatic logic [4:0] first_set(input logic [15:0] v);
    first_set = 5'h00;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 5'(k);
      end
    end
  endfunction

  function automatic logic is_app(input acpm_mode_e m);
    is_app = (m == ACPM_SYS) || (m == ACPM_USER);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins

  localparam int SW = 4 + NIRQ;

  logic [SW-1:0]   pins_s;
  logic            strap_s;
  logic            health_s;
  logic            pdc_s;
  logic            exc_s;
  logic [NIRQ-1:0] irq_s;
  logic            exc_prev_reg;
  logic [NIRQ-1:0] irq_prev_reg;

  acpm_sync #(.W(SW)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_d       ({i_test_off_strap, i_opt_health, i_opt_pdc, i_exc_req, i_evt_irq}),
    .o_q       (pins_s)
  );

  assign strap_s  = pins_s[SW-1];
  assign health_s = pins_s[SW-2];
  assign pdc_s    = pins_s[SW-3];
  assign exc_s    = pins_s[SW-4];
  assign irq_s    = pins_s[NIRQ-1:0];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      exc_prev_reg <= 1'b0;
      irq_prev_reg <= '0;
    end else begin
      exc_prev_reg <= exc_s;
      irq_prev_reg <= irq_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  acpm_mode_e       mode_reg;
  acpm_mode_e       mode_next;
  logic [31:0]      ctrl_reg;
  logic [31:0]      wload_reg;
  logic [31:0]      grant_reg;
  logic [`ACPM_S_W-1:0] stat_reg;
  logic [`ACPM_S_W-1:0] mask_reg;
  logic [FEATW-1:0] feat_reg;
  logic             lock_reg;
  logic             toff_reg;
  logic [31:0]      vaddr_next;
  logic             vjump_next;
  logic [31:0]      wdt_count;
  logic             wdt_to;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire        setup    = i_psel && !i_penable;
  wire        acc      = i_psel && i_penable;
  wire        wr       = acc && i_pwrite;
  wire        app_mode = is_app(mode_reg);
  wire        user     = (mode_reg == ACPM_USER);
  wire        hit_ctrl  = (i_paddr == `ACPM_A_CTRL);
  wire        hit_mode  = (i_paddr == `ACPM_A_MODE);
  wire        hit_vcall = (i_paddr == `ACPM_A_VCALL);
  wire        hit_wload = (i_paddr == `ACPM_A_WLOAD);
  wire        hit_wkick = (i_paddr == `ACPM_A_WKICK);
  wire        hit_grant = (i_paddr == `ACPM_A_GRANT);
  wire        hit_istat = (i_paddr == `ACPM_A_ISTAT);
  wire        hit_imask = (i_paddr == `ACPM_A_IMASK);
  wire        hit_feat  = (i_paddr == `ACPM_A_FEAT);
  wire        hit_hid   = (i_paddr == `ACPM_A_HID);
  wire        mapped   = hit_ctrl | hit_mode | hit_vcall | hit_wload | hit_wkick |
                         hit_grant | hit_istat | hit_imask | hit_feat | hit_hid;
  wire        hit_priv = hit_ctrl | hit_wload | hit_wkick | hit_grant |
                         hit_istat | hit_imask | hit_feat | hit_hid;

  // vector call word: kind bit picks system-call, low bits pick the index
  wire        vc_sys   = i_pwdata[`ACPM_V_KIND];
  wire [4:0]  vc_idx   = i_pwdata[4:0];
  wire        vc_range = vc_sys ? ({1'b0, vc_idx} < `ACPM_SC_VECS)
                                : ({1'b0, vc_idx} < `ACPM_FW_VECS); // RL9
  wire        vc_bad   = hit_vcall && (!vc_range || !app_mode);

  wire        wr_denied = wr && user && hit_priv;                    // RL7
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && (!mapped || (i_pwrite && (hit_priv ? user : vc_bad)));

  wire        wr_ok    = wr && mapped && !o_pslverr;
  wire        w_ctrl   = wr_ok && hit_ctrl;
  wire        w_vcall  = wr_ok && hit_vcall;
  wire        w_hid    = wr_ok && hit_hid;
  wire        w_feat   = wr_ok && hit_feat && pdc_s && !lock_reg;   // RL13

  ////////////////////////////////////////////////////////////////////////
  // watchdog

  acpm_wdt #(.CW(32)) u_wdt (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_en      (ctrl_reg[`ACPM_C_WDT_EN]),
    .i_kick    ((wr_ok && hit_wkick) || (wr_ok && hit_wload)),
    .i_load    (wload_reg),
    .o_timeout (wdt_to),
    .o_count   (wdt_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // access rights and event detection

  wire [31:0] grant_w  = (NRES == 32) ? grant_reg
                                      : (grant_reg & ((32'h1 << NRES) - 32'h1));
  wire        acc_viol = i_acc_req && user && !grant_w[i_acc_res];  // RL7
  assign o_acc_block = acc_viol;                                     // RL14
  wire        viol     = acc_viol || wr_denied;                      // RL14
  wire        exc_edge = exc_s && !exc_prev_reg;
  wire [NIRQ-1:0] irq_edge = irq_s & ~irq_prev_reg;
  wire [15:0] irq_pad  = 16'(irq_edge);
  wire        exc_take = app_mode && (viol || exc_edge);            // RL8
  wire        irq_take = app_mode && (|irq_edge);                    // RL8
  wire        test_off = toff_reg || strap_s;

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer

  always_comb begin
    mode_next  = mode_reg;
    vaddr_next = o_vec_addr;
    vjump_next = 1'b0;
    if (wdt_to) begin
      mode_next  = ACPM_BOOT;                                        // RL11
      vaddr_next = `ACPM_BOOT_VEC;
      vjump_next = 1'b1;
    end else if (exc_take) begin
      mode_next  = ACPM_SYS;
      vaddr_next = viol ? `ACPM_VIOL_VEC : `ACPM_EXC_VEC;            // RL8
      vjump_next = 1'b1;
    end else if (irq_take) begin
      mode_next  = ACPM_SYS;
      vaddr_next = vec_at(`ACPM_IRQ_BASE, first_set(irq_pad));       // RL8
      vjump_next = 1'b1;
    end else if (w_vcall) begin
      vjump_next = 1'b1;
      if (vc_sys) begin
        mode_next  = ACPM_SYS;                                       // RL10
        vaddr_next = vec_at(`ACPM_SC_BASE, vc_idx);
      end else begin
        mode_next  = ACPM_FW;                                        // RL10
        vaddr_next = vec_at(`ACPM_FW_BASE, vc_idx);
      end
    end else if (w_ctrl) begin
      case (mode_reg)
        ACPM_BOOT: begin
          if (i_pwdata[`ACPM_C_BOOT_DONE]) begin
            mode_next = test_off ? ACPM_SYS : ACPM_TEST;             // RL5 RL6
          end
        end
        ACPM_FW: begin
          if (i_pwdata[`ACPM_C_FW_RET]) begin
            mode_next = ACPM_SYS;
          end
        end
        ACPM_SYS: begin
          if (i_pwdata[`ACPM_C_TO_USER]) begin
            mode_next = ACPM_USER;
          end
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  // reset always lands in boot; only the sequencer above leaves it   RL2 RL3 RL4
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg   <= ACPM_BOOT;                                       // RL1
      o_vec_addr <= `ACPM_BOOT_VEC;
      o_vec_jump <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      o_vec_addr <= vaddr_next;
      o_vec_jump <= vjump_next;
    end
  end
  assign o_mode = mode_reg;

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg  <= 32'h0000_0000;
      wload_reg <= `ACPM_WLOAD_RST;
      grant_reg <= 32'h0000_0000;
      mask_reg  <= '0;
      feat_reg  <= '0;
    end else begin
      if (w_ctrl) begin
        ctrl_reg <= {31'h0, i_pwdata[`ACPM_C_WDT_EN]};               // RL11
      end
      if (wr_ok && hit_wload) begin
        wload_reg <= i_pwdata;
      end
      if (wr_ok && hit_grant) begin
        grant_reg <= i_pwdata;
      end
      if (wr_ok && hit_imask) begin
        mask_reg <= i_pwdata[`ACPM_S_W-1:0];
      end
      if (w_feat) begin
        feat_reg <= i_pwdata[FEATW-1:0];                             // RL13
      end
    end
  end

  // lock and test disable are sticky until the next reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_reg        <= 1'b0;
      toff_reg        <= 1'b0;
      o_test_off_burn <= 1'b0;
    end else begin
      if (w_ctrl && i_pwdata[`ACPM_C_FEAT_LOCK] && pdc_s) begin
        lock_reg <= 1'b1;
      end
      o_test_off_burn <= w_ctrl && i_pwdata[`ACPM_C_TEST_OFF] &&
                         (mode_reg == ACPM_TEST);                    // RL6
      if (w_ctrl && i_pwdata[`ACPM_C_TEST_OFF] && (mode_reg == ACPM_TEST)) begin
        toff_reg <= 1'b1;
      end
    end
  end
  assign o_feat_en = feat_reg;

  // health and ident requests, accepted only during boot
  wire hid_ok = w_hid && health_s && (mode_reg == ACPM_BOOT);        // RL12

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_selftest_start <= 1'b0;
      o_ident_send     <= 1'b0;
    end else begin
      o_selftest_start <= hid_ok && i_pwdata[0];
      o_ident_send     <= hid_ok && !i_pwdata[0] && i_pwdata[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over write-one-clear

  wire [`ACPM_S_W-1:0] stat_set = {vjump_next && w_vcall && !wdt_to && !exc_take && !irq_take,
                                   irq_take && !wdt_to && !exc_take,
                                   exc_take && !viol && !wdt_to,
                                   wdt_to,
                                   viol};
  wire [`ACPM_S_W-1:0] stat_clr = (wr_ok && hit_istat) ? i_pwdata[`ACPM_S_W-1:0] : '0;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
    end
  end
  assign o_irq = |(stat_reg & mask_reg);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wdt_abort <= 1'b0;
    end else begin
      o_wdt_abort <= wdt_to;                                         // RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  wire [31:0] mode_word = {20'h0, lock_reg, health_s, pdc_s, test_off, 3'h0, mode_reg};
  wire [31:0] rd_mux =
      hit_ctrl  ? ctrl_reg :
      hit_mode  ? mode_word :
      hit_wload ? wload_reg :
      hit_wkick ? wdt_count :
      hit_grant ? grant_reg :
      hit_istat ? 32'(stat_reg) :
      hit_imask ? 32'(mask_reg) :
      hit_feat  ? 32'(feat_reg) :
      32'h0000_0000;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      o_prdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

//--- rtl/acpm_cfg.svh
// Function
// RL1: the core tracks five privilege modes: boot, test, firmware, system and user.
// RL2: the super-system level is only ever held as exactly one of boot, test or firmware.
// RL3: boot runs start-up code, test runs production test code, firmware runs the firmware system.
// RL4: application software can never place the core in boot, test or firmware except by a vector.
// RL5: while production test stays enabled, every start-up or reset ends in test mode.
// RL6: once test mode is disabled, every start-up or reset ends in system mode.
// RL7: system mode has full access; user mode reaches only what system software granted it.
// RL8: exceptions and event interrupts each jump to a fixed class-specific ROM vector.
// RL9: eight firmware entry vectors and 32 system-call vectors exist, entered only on explicit call.
// RL10: a firmware entry vector forces firmware mode, a system-call vector forces system mode.
// RL11: a software enabled and loaded watchdog aborts irregular execution on timeout.
// RL12: with the health option on, boot may start self tests or send identification items.
// RL13: with the post-delivery option on and not locked, software may switch hardware functions.
// RL14: a user-mode access outside its rights is blocked and raises an exception; user reads of privileged registers are not blocked.
`ifndef ACPM_CFG_SVH
`define ACPM_CFG_SVH

// register byte offsets
`define ACPM_A_CTRL   12'h000
`define ACPM_A_MODE   12'h004
`define ACPM_A_VCALL  12'h008
`define ACPM_A_WLOAD  12'h00c
`define ACPM_A_WKICK  12'h010
`define ACPM_A_GRANT  12'h014
`define ACPM_A_ISTAT  12'h018
`define ACPM_A_IMASK  12'h01c
`define ACPM_A_FEAT   12'h020
`define ACPM_A_HID    12'h024

// control bits
`define ACPM_C_WDT_EN    0
`define ACPM_C_BOOT_DONE 1
`define ACPM_C_FW_RET    2
`define ACPM_C_TO_USER   3
`define ACPM_C_TEST_OFF  4
`define ACPM_C_FEAT_LOCK 5

// vector call word
`define ACPM_V_KIND   8
`define ACPM_FW_VECS  6'd8
`define ACPM_SC_VECS  6'd32

// status bits
`define ACPM_S_VIOL  0
`define ACPM_S_WDT   1
`define ACPM_S_EXC   2
`define ACPM_S_IRQ   3
`define ACPM_S_VCALL 4
`define ACPM_S_W     5

// mode register fields
`define ACPM_M_TOFF  8
`define ACPM_M_PDC   9
`define ACPM_M_HLTH  10
`define ACPM_M_LOCK  11

// rom vector map
`define ACPM_BOOT_VEC 32'h0000_0000
`define ACPM_EXC_VEC  32'h0000_0100
`define ACPM_VIOL_VEC 32'h0000_0104
`define ACPM_IRQ_BASE 32'h0000_0200
`define ACPM_FW_BASE  32'h0000_0300
`define ACPM_SC_BASE  32'h0000_0400

// reset values
`define ACPM_WLOAD_RST 32'h0001_0000

`endif

//--- rtl/acpm_pkg.sv
package acpm_pkg;
  typedef enum logic [4:0] {
    ACPM_BOOT = 5'b00001,
    ACPM_TEST = 5'b00010,
    ACPM_FW   = 5'b00100,
    ACPM_SYS  = 5'b01000,
    ACPM_USER = 5'b10000
  } acpm_mode_e;
endpackage

//--- rtl/acpm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acpm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- rtl/acpm_wdt.sv
`timescale 1ns/1ps
`default_nettype none
module acpm_wdt #(
  parameter int CW = 32
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_en,
  input  wire logic          i_kick,
  input  wire logic [CW-1:0] i_load,
  output logic               o_timeout,
  output logic      [CW-1:0] o_count
);
  logic [CW-1:0] cnt_next;
  logic          to_next;

  // counts down while enabled; kick or disable restarts from the load value
  assign to_next  = i_en && !i_kick && (o_count <= {{(CW-1){1'b0}}, 1'b1});
  assign cnt_next = (!i_en || i_kick || to_next) ? i_load : o_count - {{(CW-1){1'b0}}, 1'b1};

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count   <= '0;
      o_timeout <= 1'b0;
    end else begin
      o_count   <= cnt_next;
      o_timeout <= to_next;
    end
  end
endmodule
`default_nettype wire

//--- tb/acpm_priv_props.sv
`timescale 1ns/1ps
`default_nettype none
module acpm_priv_props
  import acpm_pkg::*;
(
  // clock and reset
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst_b,
  // access check
  input wire logic                 i_acc_req,
  input wire logic                 o_acc_block,
  // mode, vector and watchdog abort
  input wire acpm_pkg::acpm_mode_e o_mode,
  input wire logic                 o_vec_jump,
  input wire logic [31:0]          o_vec_addr,
  input wire logic                 o_wdt_abort
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  chk_mode_onehot: assert property ($onehot(o_mode))
    else $error("mode is not one of the five");
  chk_block_user: assert property (o_acc_block |-> i_acc_req && o_mode == ACPM_USER)
    else $error("access blocked outside user mode");
  chk_block_exc: assert property (o_acc_block |-> ##[1:4] o_vec_jump && o_vec_addr == 32'h0000_0104)
    else $error("blocked access raised no exception");
  chk_fw_mode: assert property (o_vec_jump && o_vec_addr[31:5] == 27'h18 |-> o_mode == ACPM_FW)
    else $error("firmware vector without firmware mode");
  chk_sc_mode: assert property (o_vec_jump && o_vec_addr[31:7] == 25'h8 |-> o_mode == ACPM_SYS)
    else $error("system call vector without system mode");
  chk_vec_rom: assert property (o_vec_jump |-> o_vec_addr inside {32'h0, 32'h100, 32'h104,
    [32'h200:32'h21c], [32'h300:32'h31c], [32'h400:32'h47c]} && o_vec_addr[1:0] == 2'h0)
    else $error("jump target outside vector table");
  chk_fw_entry: assert property (o_mode == ACPM_FW && $past(o_mode) != ACPM_FW |-> o_vec_jump)
    else $error("firmware mode entered without vector");
  chk_test_entry: assert property (o_mode == ACPM_TEST && $past(o_mode) != ACPM_TEST |->
    $past(o_mode) == ACPM_BOOT)
    else $error("test mode entered from outside boot");
  chk_abort_boot: assert property (o_wdt_abort |-> ##[0:2] o_mode == ACPM_BOOT)
    else $error("watchdog abort left mode running");
endmodule
`default_nettype wire

//--- tb/cpu_privilege_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "acpm_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cpu_privilege_mode_control_bench;
  import acpm_pkg::*;
  logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, strap = 0, hlth = 1, pdc = 1, exc = 0, acc = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, vaddr, rd, v;
  logic [7:0]  irq = 0;
  logic [4:0]  res = 0;
  logic [15:0] feat;
  logic        pready, er, blk, vjump, abort, burn, selft, ident, oirq;
  acpm_mode_e  mode, m_mode;
  logic [31:0] jq[$];
  acpm_mode_e  mq[$];
  int          error_cnt = 0, checks_done = 0, n_ident = 0, n_self = 0, n_burn = 0, n_abort = 0, r, n;
  wire logic   er_w;

  acpm_priv_ctrl u_acpm_priv_ctrl (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(er_w), .i_test_off_strap(strap), .i_opt_health(hlth), .i_opt_pdc(pdc), .i_exc_req(exc),
    .i_evt_irq(irq), .i_acc_req(acc), .i_acc_res(res), .o_acc_block(blk), .o_mode(mode), .o_vec_jump(vjump),
    .o_vec_addr(vaddr), .o_wdt_abort(abort), .o_test_off_burn(burn), .o_selftest_start(selft),
    .o_ident_send(ident), .o_feat_en(feat), .o_irq(oirq));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (vjump === 1'b1) begin
      jq.push_back(vaddr);
      mq.push_back(mode);
    end
    n_ident += int'(ident === 1'b1);
    n_self += int'(selft === 1'b1);
    n_burn += int'(burn === 1'b1);
    n_abort += int'(abort === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = er_w;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      give_verdict();
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic jmp(input logic [31:0] ea, input logic cm, input acpm_mode_e em);
    logic [31:0] a;
    acpm_mode_e  m;
    n = 0;
    while (jq.size() == 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      give_verdict();
    end
    a = jq.pop_front();
    m = mq.pop_front();
    `CHK(a, ea)
    if (cm) `CHK(m, em)
  endtask
  task mchk();
    @(negedge clk);
    `CHK(mode, m_mode)
    @(posedge clk);
  endtask
  task lvl(input logic e);
    @(negedge clk);
    `CHK(oirq, e)
    @(posedge clk);
  endtask
  task rst();
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    jq.delete();
    mq.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hb3b77715));
    rst();
    m_mode = ACPM_BOOT;
    mchk();
    apb(1'b0, `ACPM_A_MODE, 32'h0);
    `CHK(rd, 32'h0000_0601)
    apb(1'b1, `ACPM_A_HID, 32'h2);
    apb(1'b1, `ACPM_A_HID, 32'h3);
    `CHK(n_ident, 1)
    `CHK(n_self, 1)
    apb(1'b1, `ACPM_A_CTRL, 32'h2);
    m_mode = ACPM_TEST;
    mchk();
    apb(1'b1, `ACPM_A_CTRL, 32'h10);
    `CHK(n_burn, 1)
    apb(1'b0, `ACPM_A_MODE, 32'h0);
    `CHK(rd, 32'h0000_0702)
    strap <= 1'b1;
    rst();
    apb(1'b1, `ACPM_A_CTRL, 32'h2);
    m_mode = ACPM_SYS;
    mchk();
    v = $urandom;
    apb(1'b1, `ACPM_A_FEAT, v);
    `CHK(feat, v[15:0])
    apb(1'b1, `ACPM_A_CTRL, 32'h20);
    apb(1'b1, `ACPM_A_FEAT, ~v);
    `CHK(feat, v[15:0])
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, `ACPM_A_VCALL, 32'h100 | i);
      jmp(32'h400 + 4 * i, 1'b1, ACPM_SYS);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `ACPM_A_VCALL, i);
      jmp(32'h300 + 4 * i, 1'b1, ACPM_FW);
      apb(1'b1, `ACPM_A_VCALL, 32'h100);
      `CHK(er, 1'b1)
      apb(1'b1, `ACPM_A_CTRL, 32'h4);
      mchk();
    end
    apb(1'b1, `ACPM_A_VCALL, 32'h8);
    `CHK(er, 1'b1)
    `CHK(jq.size(), 0)
    apb(1'b0, 12'h040, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    r = $urandom_range(31, 0);
    apb(1'b1, `ACPM_A_GRANT, 32'h1 << r);
    apb(1'b1, `ACPM_A_CTRL, 32'h8);
    m_mode = ACPM_USER;
    mchk();
    acc <= 1'b1;
    res <= 5'(r);
    @(negedge clk);
    `CHK(blk, 1'b0)
    @(posedge clk);
    res <= 5'(r) ^ 5'h1;
    @(negedge clk);
    `CHK(blk, 1'b1)
    @(posedge clk);
    acc <= 1'b0;
    jmp(32'h104, 1'b1, ACPM_SYS);
    apb(1'b1, `ACPM_A_CTRL, 32'h8);
    apb(1'b1, `ACPM_A_GRANT, 32'h0);
    `CHK(er, 1'b1)
    jmp(32'h104, 1'b1, ACPM_SYS);
    apb(1'b1, `ACPM_A_IMASK, 32'hc);
    r = $urandom_range(7, 0);
    irq <= 8'h1 << r;
    repeat (4) @(posedge clk);
    irq <= 8'h0;
    jmp(32'h200 + 4 * r, 1'b0, ACPM_SYS);
    lvl(1'b1);
    apb(1'b0, `ACPM_A_ISTAT, 32'h0);
    `CHK(rd & 32'h8, 32'h8)
    apb(1'b1, `ACPM_A_IMASK, 32'h4);
    lvl(1'b0);
    exc <= 1'b1;
    repeat (4) @(posedge clk);
    exc <= 1'b0;
    jmp(32'h100, 1'b1, ACPM_SYS);
    lvl(1'b1);
    apb(1'b1, `ACPM_A_ISTAT, 32'h1f);
    lvl(1'b0);
    apb(1'b1, `ACPM_A_WLOAD, 32'd20);
    apb(1'b1, `ACPM_A_CTRL, 32'h1);
    apb(1'b0, `ACPM_A_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    n = 0;
    while (n_abort == 0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK(n_abort, 1)
    jmp(32'h0, 1'b1, ACPM_BOOT);
    give_verdict();
  end
endmodule
bind acpm_priv_ctrl acpm_priv_props u_acpm_priv_props (.i_ref_clk, .i_rst_b, .i_acc_req, .o_acc_block,
  .o_mode, .o_vec_jump, .o_vec_addr, .o_wdt_abort);
`default_nettype wire
